// ### rtl/sbd_datapath.sv
// sbd_datapath: decode and execute of both subtract-with-borrow forms, with
// working registers, status word and a small data memory behind Avalon-MM.
// assumes one clock domain; the master holds each request until waitrequest low.
`timescale 1ns/1ps
module sbd_datapath #(
  parameter int MEM_WORDS = 64
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [15:0] status_word_o
);
  localparam int AW = $clog2(MEM_WORDS);

  // memory window is 4 bytes per word and must fit below 0x1000
  if (MEM_WORDS < 2 || MEM_WORDS > 256 || (1 << AW) != MEM_WORDS) begin : g_bad_mem_words
    $error("sbd_datapath: MEM_WORDS must be a power of two in 2..256");
  end

  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] wreg_q [16];
  logic [15:0] wreg_d [16];
  logic [15:0] mem_q [MEM_WORDS];
  logic [15:0] sr_q, sr_d;
  logic [23:0] insn_q, insn_d;
  logic err_q, err_d;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [15:0] mem_wd;

  // pointer arithmetic for indirect modes: returns {effective addr, new ptr}
  function automatic logic [31:0] addr_calc(input logic [2:0] mode, input logic [15:0] ptr,
                                            input logic [15:0] step);
    logic [15:0] ea;
    logic [15:0] np;
    ea = ptr;
    np = ptr;
    unique case (mode)
      sbd_pkg::SBD_POSTINC: np = ptr + step;
      sbd_pkg::SBD_POSTDEC: np = ptr - step;
      sbd_pkg::SBD_PREINC: begin
        np = ptr + step;
        ea = np;
      end
      sbd_pkg::SBD_PREDEC: begin
        np = ptr - step;
        ea = np;
      end
      default: np = ptr;
    endcase
    return {ea, np};
  endfunction : addr_calc

  // byte-enable merge for the low half of a bus word
  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge

  logic req;
  logic commit;
  assign req = avs_read_i | avs_write_i;
  // a transfer completes at the edge where the master sees waitrequest low
  assign commit = req & ~wait_q;

  // bus handshake: one wait state for every access, read data registered
  always_comb begin
    wait_d = ~(req & wait_q);
    rdata_d = rdata_q;
    if (req && wait_q && avs_read_i) begin
      rdata_d = 32'h00000000;
      if (avs_address_i == sbd_pkg::OFF_INSN) begin
        rdata_d = {8'h00, insn_q};
      end else if (avs_address_i == sbd_pkg::OFF_STATUS) begin
        rdata_d = {16'h0000, sr_q};
      end else if (avs_address_i == sbd_pkg::OFF_EXEC) begin
        rdata_d = {31'h00000000, err_q};
      end else if (avs_address_i[11:6] == sbd_pkg::OFF_WREG_BASE[11:6]) begin
        rdata_d = {16'h0000, wreg_q[avs_address_i[5:2]]};
      end else if (avs_address_i >= sbd_pkg::OFF_MEM_BASE &&
                   avs_address_i < sbd_pkg::OFF_MEM_BASE + 12'(4 * MEM_WORDS)) begin
        rdata_d = {16'h0000, mem_q[AW'((avs_address_i - sbd_pkg::OFF_MEM_BASE) >> 2)]};
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // decode of the word being written to the instruction register
  logic [23:0] iw;
  logic opc_ok, is_lit, is_byte, q_ok, p_ok, legal;
  logic [3:0] f_w, f_d, f_s;
  logic [2:0] f_q, f_p;
  logic [4:0] f_k;
  logic [15:0] step;
  assign iw = avs_writedata_i[23:0];
  assign opc_ok = iw[sbd_pkg::F_OPC_LSB +: 5] == sbd_pkg::OPC_HI;
  assign is_lit = iw[sbd_pkg::F_P_LSB+1 +: 2] == sbd_pkg::LIT_TAG;
  assign f_w = iw[sbd_pkg::F_W_LSB +: 4];
  assign is_byte = iw[sbd_pkg::F_B];
  assign f_q = iw[sbd_pkg::F_Q_LSB +: 3];
  assign f_d = iw[sbd_pkg::F_D_LSB +: 4];
  assign f_p = iw[sbd_pkg::F_P_LSB +: 3];
  assign f_s = iw[sbd_pkg::F_S_LSB +: 4];
  assign f_k = iw[4:0];
  assign step = is_byte ? 16'h0001 : 16'h0002;
  // codes 6 and 7 have no meaning as a target mode; refused as illegal
  assign q_ok = f_q <= sbd_pkg::SBD_PREDEC;
  assign p_ok = is_lit || f_p <= sbd_pkg::SBD_PREDEC;
  assign legal = opc_ok && q_ok && p_ok;

  // operand fetch, subtraction and flag computation
  logic [31:0] src_ac, dst_ac;
  logic [15:0] src_word, dst_word, a, b, ax, bx;
  logic [16:0] sum;
  logic [8:0] dc_w;
  logic [4:0] dc_b;
  logic cin, res_zero, ovf;
  logic [15:0] res;
  assign src_ac = addr_calc(f_p, wreg_q[f_s], step);
  assign dst_ac = addr_calc(f_q, wreg_q[f_d], step);
  // word index comes from the effective address in the upper half, not the new pointer
  assign src_word = mem_q[src_ac[17 +: AW]];
  assign dst_word = mem_q[dst_ac[17 +: AW]];
  always_comb begin
    a = wreg_q[f_w];
    if (is_lit) begin
      b = {11'h000, f_k};
    end else if (f_p == sbd_pkg::SBD_DIRECT) begin
      b = wreg_q[f_s];
    end else begin
      b = (is_byte && src_ac[16]) ? {8'h00, src_word[15:8]} : src_word;
    end
  end
  assign cin = sr_q[sbd_pkg::SR_C];
  // byte operands ride in the upper byte so one adder serves both widths;
  // the all-ones low byte of the inverted operand passes the carry into bit 8
  assign ax = is_byte ? {a[7:0], 8'h00} : a;
  assign bx = is_byte ? {b[7:0], 8'h00} : b;
  assign sum = {1'b0, ax} + {1'b0, ~bx} + {16'h0000, cin};
  assign dc_w = {1'b0, a[7:0]} + {1'b0, ~b[7:0]} + {8'h00, cin};
  assign dc_b = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
  assign res = is_byte ? {8'h00, sum[15:8]} : sum[15:0];
  assign res_zero = is_byte ? (sum[15:8] == 8'h00) : (sum[15:0] == 16'h0000);
  assign ovf = (ax[15] ^ bx[15]) & (sum[15] ^ ax[15]);

  // architectural state: instruction, status word, working registers, memory
  always_comb begin
    insn_d = insn_q;
    sr_d = sr_q;
    err_d = err_q;
    wreg_d = wreg_q;
    mem_we = 1'b0;
    mem_wa = dst_ac[17 +: AW];
    mem_wd = dst_word;
    if (commit && avs_write_i) begin
      if (avs_address_i == sbd_pkg::OFF_INSN) begin
        insn_d = iw;
        if (!legal) begin
          err_d = 1'b1;
        end else begin
          sr_d[sbd_pkg::SR_C] = sum[16];
          sr_d[sbd_pkg::SR_N] = sum[15];
          sr_d[sbd_pkg::SR_OV] = ovf;
          sr_d[sbd_pkg::SR_DC] = is_byte ? dc_b[4] : dc_w[8];
          if (!res_zero) begin
            sr_d[sbd_pkg::SR_Z] = 1'b0;
          end
          // source pointer first; a target pointer on the same register wins
          if (!is_lit && f_p != sbd_pkg::SBD_DIRECT) begin
            wreg_d[f_s] = src_ac[15:0];
          end
          if (f_q == sbd_pkg::SBD_DIRECT) begin
            wreg_d[f_d] = is_byte ? {wreg_q[f_d][15:8], res[7:0]} : res;
          end else begin
            wreg_d[f_d] = dst_ac[15:0];
            mem_we = 1'b1;
            if (!is_byte) begin
              mem_wd = res;
            end else if (dst_ac[16]) begin
              mem_wd = {res[7:0], dst_word[7:0]};
            end else begin
              mem_wd = {dst_word[15:8], res[7:0]};
            end
          end
        end
      end else if (avs_address_i == sbd_pkg::OFF_STATUS) begin
        sr_d = be_merge(sr_q, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      end else if (avs_address_i == sbd_pkg::OFF_EXEC) begin
        if (avs_byteenable_i[0] && avs_writedata_i[sbd_pkg::EXEC_ERR]) begin
          err_d = 1'b0;
        end
      end else if (avs_address_i[11:6] == sbd_pkg::OFF_WREG_BASE[11:6]) begin
        wreg_d[avs_address_i[5:2]] = be_merge(wreg_q[avs_address_i[5:2]],
                                              avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      end else if (avs_address_i >= sbd_pkg::OFF_MEM_BASE &&
                   avs_address_i < sbd_pkg::OFF_MEM_BASE + 12'(4 * MEM_WORDS)) begin
        mem_we = 1'b1;
        mem_wa = AW'((avs_address_i - sbd_pkg::OFF_MEM_BASE) >> 2);
        mem_wd = be_merge(mem_q[mem_wa], avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      insn_q <= sbd_pkg::INSN_RESET;
      sr_q <= sbd_pkg::SR_RESET;
      err_q <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        wreg_q[i] <= sbd_pkg::WREG_RESET;
      end
    end else begin
      insn_q <= insn_d;
      sr_q <= sr_d;
      err_q <= err_d;
      wreg_q <= wreg_d;
    end
  end

  // data memory has no reset, as a real RAM would not
  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // status word mirrored on a port, loaded on the same edge as the register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      status_word_o <= sbd_pkg::SR_RESET;
    end else begin
      status_word_o <= sr_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
endmodule : sbd_datapath

// ### rtl/sbd_pkg.sv
// sbd_pkg: constants for the subtract-with-borrow datapath (map, fields, flags)
// assumes a single 100 MHz core clock and an Avalon-MM register slave
// Operation
// - literal form: 0101 1, then 11 above literal
// - register form: same opcode, source mode and register
// - four-bit field picks base working register
// - width bit: 0 word, 1 byte
// - three-bit field picks target addressing mode
// - four-bit field picks target or pointer register
// - register form: source mode uses same variants
// - register form: four-bit field picks source register
package sbd_pkg;
  // register map, byte addresses
  localparam logic [11:0] OFF_INSN = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_EXEC = 12'h008;
  localparam logic [11:0] OFF_WREG_BASE = 12'h040;
  localparam logic [11:0] OFF_MEM_BASE = 12'h100;
  // instruction word fields
  localparam logic [4:0] OPC_HI = 5'h0B;
  localparam int F_OPC_LSB = 19;
  localparam int F_W_LSB = 15;
  localparam int F_B = 14;
  localparam int F_Q_LSB = 11;
  localparam int F_D_LSB = 7;
  localparam int F_P_LSB = 4;
  localparam int F_S_LSB = 0;
  localparam logic [1:0] LIT_TAG = 2'h3;
  // status word and exec register bit positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_OV = 2;
  localparam int SR_N = 3;
  localparam int SR_DC = 8;
  localparam int EXEC_ERR = 0;
  // reset values
  localparam logic [15:0] SR_RESET = 16'h0000;
  localparam logic [15:0] WREG_RESET = 16'h0000;
  localparam logic [23:0] INSN_RESET = 24'h000000;
  // addressing modes of source and target
  typedef enum logic [2:0] {
    SBD_DIRECT = 3'h0,
    SBD_IND = 3'h1,
    SBD_POSTINC = 3'h2,
    SBD_POSTDEC = 3'h3,
    SBD_PREINC = 3'h4,
    SBD_PREDEC = 3'h5
  } sbd_mode_t;
endpackage : sbd_pkg

// ### bench/sbd_datapath_sva.sv
// sbd_datapath_sva: handshake and status word checks
// assumes binding onto sbd_datapath ports, one clock
`timescale 1ns/1ps
module sbd_datapath_sva (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [15:0] status_word_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // exactly one wait state per access
  chk_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("no answer after request");
  chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  chk_idle_wait: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("answer without request");
  chk_wait_reset: assert property ($fell(rst_i) |-> avs_waitrequest_o)
    else $error("waitrequest low after reset");
  // the hole at 0x00C-0x03F reads as zero; reads other than the instruction have a zero upper half
  chk_rd_unmapped: assert property (!avs_waitrequest_o && avs_read_i &&
    avs_address_i inside {[12'h00C:12'h03F]} |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_rd_upper: assert property (!avs_waitrequest_o && avs_read_i &&
    avs_address_i != sbd_pkg::OFF_INSN |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("register read upper half not zero");
  // zero flag only rises through a direct status write, never by execution
  chk_zero_sticky: assert property (
    $rose(status_word_o[sbd_pkg::SR_Z]) |-> $past(avs_write_i && !avs_waitrequest_o &&
    avs_address_i == sbd_pkg::OFF_STATUS, 1)) else $error("zero flag set by result");
  chk_status_cause: assert property (
    !$stable(status_word_o) |-> $past(avs_write_i && !avs_waitrequest_o, 1))
    else $error("status changed without write");
endmodule : sbd_datapath_sva

// ### bench/sbd_core_model.sv
// sbd_core_model: core side master issuing register bus transfers
// assumes the slave updates its outputs with nonblocking assignment
`timescale 1ns/1ps
module sbd_core_model (
  input wire logic mclk_i,
  input wire logic [31:0] avs_readdata_i,
  input wire logic avs_waitrequest_i,
  output logic [11:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o
);
  initial begin
    avs_address_o = 12'h000;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'h0;
  end
  // one edge is let pass first so a release and a new raise never share a step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_write_o <= w;
    avs_read_o <= !w;
    @(posedge mclk_i);
    while (avs_waitrequest_i !== 1'b0 && n < 50) begin
      n++;
      @(posedge mclk_i);
    end
    q = avs_readdata_i;
    ok = (n < 50);
    avs_write_o <= 1'b0;
    avs_read_o <= 1'b0;
  endtask : xfer
endmodule : sbd_core_model

// ### bench/sbd_datapath_tb.sv
// sbd_datapath_tb: executes both subtract forms through the register bus
// assumes sbd_pkg, sbd_core_model and sbd_datapath_sva are compiled first
`timescale 1ns/1ps
module sbd_datapath_tb;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic wreq;
  logic [15:0] sw;
  int error_cnt = 0;
  int cmp_count = 0;
  // 100 MHz core clock
  initial forever #5 mclk_i = ~mclk_i;
  sbd_core_model core (.mclk_i(mclk_i), .avs_readdata_i(rdat), .avs_waitrequest_i(wreq),
    .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr), .avs_writedata_o(wdat));
  sbd_datapath dut (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .status_word_o(sw));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // a hung slave ends the run through the same report
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    logic ok;
    core.xfer(w, a, d, q, ok);
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: bus access hung", $time);
      summarize();
    end
  endtask : bus
  task automatic wreg(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, {16'h0000, d}, q);
  endtask : wreg
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rchk
  // src is {mode, reg} or {2'h3, literal}
  task automatic exec(input logic b, input logic [3:0] wb, input logic [2:0] m,
      input logic [3:0] t, input logic [6:0] src, input logic [4:0] opc);
    logic [31:0] q;
    bus(1'b1, sbd_pkg::OFF_INSN, {8'h00, opc, wb, b, m, t, src}, q);
  endtask : exec
  // main sequence: reset values, worked cases, every target mode, refusals
  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk(12'h004, 32'h0);
    rchk(12'h040, 32'h0);
    wreg(12'h050, 16'h1782);
    wreg(12'h054, 16'h7804);
    exec(1'b1, 4'h4, 3'h0, 4'h5, {2'h3, 5'h10}, sbd_pkg::OPC_HI);
    rchk(12'h054, 32'h00007871);
    rchk(12'h004, 32'h00000105);
    check({16'h0000, sw}, 32'h00000105);
    wreg(12'h040, 16'h0009);
    wreg(12'h048, 16'h0004);
    wreg(12'h108, 16'hA557);
    wreg(12'h004, 16'h0002);
    exec(1'b0, 4'h0, 3'h2, 4'h2, {2'h3, 5'h08}, sbd_pkg::OPC_HI);
    rchk(12'h108, 32'h0);
    rchk(12'h048, 32'h00000006);
    rchk(12'h004, 32'h00000103);
    wreg(12'h05C, 16'h2450);
    wreg(12'h060, 16'h0008);
    wreg(12'h064, 16'h0022);
    wreg(12'h110, 16'h92E4);
    wreg(12'h144, 16'hA557);
    wreg(12'h004, 16'h0000);
    exec(1'b0, 4'h7, 3'h2, 4'h9, {3'h2, 4'h8}, sbd_pkg::OPC_HI);
    rchk(12'h144, 32'h0000916B);
    rchk(12'h060, 32'h0000000A);
    rchk(12'h064, 32'h00000024);
    rchk(12'h004, 32'h0000000C);
    wreg(12'h044, 16'h0010);
    wreg(12'h04C, 16'h0050);
    wreg(12'h058, 16'h0020);
    wreg(12'h11C, 16'h1234);
    wreg(12'h004, 16'h0001);
    exec(1'b1, 4'h3, 3'h5, 4'h1, {3'h0, 4'h6}, sbd_pkg::OPC_HI);
    rchk(12'h11C, 32'h00003034);
    rchk(12'h044, 32'h0000000F);
    rchk(12'h004, 32'h00000101);
    for (int m = 1; m < 6; m++) begin
      wreg(12'h044, 16'h0010);
      exec(1'b0, 4'h0, m[2:0], 4'h1, {2'h3, 5'h00}, sbd_pkg::OPC_HI);
      rchk(12'h044, (m == 2 || m == 4) ? 32'h00000012 :
        (m == 3 || m == 5) ? 32'h0000000E : 32'h00000010);
    end
    exec(1'b0, 4'h0, 3'h6, 4'h1, {2'h3, 5'h01}, sbd_pkg::OPC_HI);
    rchk(12'h008, 32'h00000001);
    wreg(12'h008, 16'h0001);
    rchk(12'h008, 32'h0);
    exec(1'b0, 4'h0, 3'h0, 4'h1, {2'h3, 5'h01}, 5'h0A);
    rchk(12'h008, 32'h00000001);
    rchk(12'h044, 32'h0000000E);
    rchk(12'h020, 32'h0);
    summarize();
  end
endmodule : sbd_datapath_tb
bind sbd_datapath sbd_datapath_sva chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .status_word_o(status_word_o));
